// ### src/link_probe_scheduler.sv
`default_nettype none
module link_probe_scheduler
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// probe node packet request
	output logic probe_node_valid,
	output logic [7:0] probe_node_addr,
	// probe response from the segment
	input wire logic probe_response_valid,
	input wire logic [7:0] probe_response_addr,
	// device admitted to the link
	output logic admit_valid,
	output logic [7:0] admit_addr,
	// address assignment packets
	output logic tag_lookup_valid,
	output logic [7:0] tag_lookup_addr,
	input wire logic identify_resp_valid,
	output logic set_address_valid,
	output logic [7:0] set_address_addr,
	output logic identify_valid,
	output logic [7:0] identify_addr
);
	import link_probe_pkg::*;

	typedef struct packed
	{
		logic run;
		logic [7:0] first_p;
		logic [7:0] len_p;
		logic [7:0] first_a;
		logic [7:0] len_a;
		logic [15:0] hold;
		logic [15:0] t1;
		logic [15:0] t3;
		logic [7:0] old_a;
		logic [7:0] new_a;
		logic done;
		logic fail;
		logic [255:0] live;
		logic [7:0] live_cnt;
		logic [7:0] cur;
		logic none;
		probe_st_t pst;
		assign_st_t ast;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pn_v;
		logic [7:0] pn_a;
		logic ad_v;
		logic [7:0] ad_a;
		logic lk_v;
		logic [7:0] lk_a;
		logic sa_v;
		logic [7:0] sa_a;
		logic id_v;
		logic [7:0] id_a;
		logic pt_start;
		logic [TMR_W-1:0] pt_limit;
		logic at_start;
		logic [TMR_W-1:0] at_limit;
	} sched_st_t;

	sched_st_t st_r;
	sched_st_t st_nxt;
	logic tick;
	logic pt_exp;
	logic at_exp;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a <= OFS_STATUS);
	endfunction

	// 9-bit compare so a region running past 255 still works
	function automatic logic in_skip(input logic [8:0] a, input logic [7:0] f, input logic [7:0] l);
		in_skip = (a >= {1'b0, f}) && (a < ({1'b0, f} + {1'b0, l}));
	endfunction

	// bit 8 set means no address left in this pass
	function automatic logic [8:0] start_addr(input logic [7:0] f, input logic [7:0] l);
		logic [8:0] a;
		a = {1'b0, ADDR_MIN};
		if (in_skip(a, f, l))
			a = {1'b0, f} + {1'b0, l};
		start_addr = a;
	endfunction

	function automatic logic [8:0] next_addr(input logic [7:0] c, input logic [7:0] f, input logic [7:0] l);
		logic [8:0] a;
		a = {1'b0, c} + 9'h001;
		if (in_skip(a, f, l))
			a = {1'b0, f} + {1'b0, l};
		if (a > {1'b0, ADDR_MAX})
			a = 9'h100;
		next_addr = a;
	endfunction

	tick_gen u_tick
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick)
	);

	wait_timer u_probe_tmr
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(st_r.pt_start),
		.limit(st_r.pt_limit),
		.expired(pt_exp)
	);

	wait_timer u_assign_tmr
	(
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.start(st_r.at_start),
		.limit(st_r.at_limit),
		.expired(at_exp)
	);

	always_comb
	begin
		logic wr;
		logic clr;
		logic gap;
		logic [8:0] nx;
		logic [24:0] span;
		wr = 1'b0;
		clr = 1'b0;
		gap = 1'b0;
		nx = '0;
		span = '0;
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		st_nxt.pn_v = 1'b0;
		st_nxt.ad_v = 1'b0;
		st_nxt.lk_v = 1'b0;
		st_nxt.sa_v = 1'b0;
		st_nxt.id_v = 1'b0;
		st_nxt.pt_start = 1'b0;
		st_nxt.at_start = 1'b0;

		// one wait state keeps pready and prdata straight from flops
		if (psel && penable && !st_r.pready)
		begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = !is_mapped(paddr);
			unique case (paddr)
				OFS_CTRL: st_nxt.prdata = {31'h0, st_r.run};
				OFS_SKIP: st_nxt.prdata = {16'h0, st_r.len_p, st_r.first_p};
				OFS_HOLD: st_nxt.prdata = {16'h0, st_r.hold};
				OFS_T1: st_nxt.prdata = {16'h0, st_r.t1};
				OFS_T3: st_nxt.prdata = {16'h0, st_r.t3};
				OFS_ASSIGN: st_nxt.prdata = {16'h0, st_r.new_a, st_r.old_a};
				OFS_STATUS: st_nxt.prdata = {12'h0, st_r.none, st_r.fail, st_r.done,
					st_r.ast != A_IDLE, st_r.live_cnt, st_r.cur};
				default: st_nxt.prdata = 32'h0;
			endcase
		end
		wr = psel && penable && st_r.pready && pwrite && is_mapped(paddr);

		if (wr)
		begin
			unique case (paddr)
				OFS_CTRL:
				begin
					st_nxt.run = pwdata[CTRL_RUN_BIT];
					clr = pwdata[CTRL_CLR_BIT];
				end
				OFS_SKIP:
				begin
					// pending only, active copy loads at wrap
					st_nxt.first_p = pwdata[7:0];
					st_nxt.len_p = pwdata[15:8];
				end
				OFS_HOLD: st_nxt.hold = pwdata[15:0];
				OFS_T1: st_nxt.t1 = pwdata[15:0];
				OFS_T3: st_nxt.t3 = pwdata[15:0];
				OFS_ASSIGN:
				begin
					// start ignored while an assignment is running
					if (st_r.ast == A_IDLE && pwdata[ASSIGN_GO_BIT])
					begin
						st_nxt.old_a = pwdata[7:0];
						st_nxt.new_a = pwdata[15:8];
						st_nxt.done = 1'b0;
						st_nxt.fail = 1'b0;
						st_nxt.ast = A_LOOK;
					end
				end
				default:
				begin
				end
			endcase
		end

		// clear first so an admission in the same cycle wins
		if (clr)
		begin
			st_nxt.live = '0;
			st_nxt.live_cnt = '0;
		end

		unique case (st_r.pst)
			P_IDLE:
			begin
				if (st_r.none)
				begin
					// whole range skipped: retry with the pending setting
					st_nxt.first_a = st_r.first_p;
					st_nxt.len_a = st_r.len_p;
					nx = start_addr(st_r.first_p, st_r.len_p);
					st_nxt.none = nx[8];
					if (!nx[8])
						st_nxt.cur = nx[7:0];
				end
				else if (st_r.run)
				begin
					st_nxt.pn_v = 1'b1;
					st_nxt.pn_a = st_r.cur;
					st_nxt.pt_start = 1'b1;
					st_nxt.pt_limit = {8'h0, st_r.t1};
					st_nxt.pst = P_RESP;
				end
			end
			P_RESP:
			begin
				// only the address just probed may join the link
				if (probe_response_valid && probe_response_addr == st_r.pn_a)
				begin
					st_nxt.ad_v = 1'b1;
					st_nxt.ad_a = st_r.pn_a;
					if (!st_nxt.live[st_r.pn_a])
					begin
						st_nxt.live[st_r.pn_a] = 1'b1;
						st_nxt.live_cnt = st_nxt.live_cnt + 8'h01;
					end
					gap = 1'b1;
				end
				else if (pt_exp && !st_r.pt_start)
					gap = 1'b1;
			end
			P_GAP:
			begin
				if (pt_exp && !st_r.pt_start)
				begin
					nx = next_addr(st_r.cur, st_r.first_a, st_r.len_a);
					if (nx[8])
					begin
						st_nxt.first_a = st_r.first_p;
						st_nxt.len_a = st_r.len_p;
						nx = start_addr(st_r.first_p, st_r.len_p);
						st_nxt.none = nx[8];
					end
					if (!nx[8])
						st_nxt.cur = nx[7:0];
					st_nxt.pst = P_IDLE;
				end
			end
		endcase

		// gap grows with hold time and with devices already live
		if (gap)
		begin
			span = 25'(st_r.hold * ({1'b0, st_r.live_cnt} + 9'h001));
			st_nxt.pt_start = 1'b1;
			st_nxt.pt_limit = span[TMR_W-1:0];
			st_nxt.pst = P_GAP;
		end

		unique case (st_r.ast)
			A_IDLE:
			begin
			end
			A_LOOK:
			begin
				st_nxt.lk_v = 1'b1;
				st_nxt.lk_a = st_r.old_a;
				st_nxt.at_start = 1'b1;
				st_nxt.at_limit = {8'h0, st_r.t1};
				st_nxt.ast = A_ID;
			end
			A_ID:
			begin
				if (identify_resp_valid)
				begin
					st_nxt.sa_v = 1'b1;
					st_nxt.sa_a = st_r.new_a;
					// device leaves its old address and must be probed anew
					if (st_nxt.live[st_r.old_a])
					begin
						st_nxt.live[st_r.old_a] = 1'b0;
						st_nxt.live_cnt = st_nxt.live_cnt - 8'h01;
					end
					st_nxt.at_start = 1'b1;
					st_nxt.at_limit = {8'h0, st_r.t3};
					st_nxt.ast = A_PR;
				end
				else if (at_exp && !st_r.at_start)
				begin
					// late identify is not seen, sequence stops here
					st_nxt.fail = 1'b1;
					st_nxt.ast = A_IDLE;
				end
			end
			A_PR:
			begin
				if (st_r.ad_v && st_r.ad_a == st_r.new_a)
					st_nxt.ast = A_IDENT;
				else if (at_exp && !st_r.at_start)
				begin
					st_nxt.fail = 1'b1;
					st_nxt.ast = A_IDLE;
				end
			end
			A_IDENT:
			begin
				st_nxt.id_v = 1'b1;
				st_nxt.id_a = st_r.new_a;
				st_nxt.done = 1'b1;
				st_nxt.ast = A_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_r <= '0;
			st_r.first_p <= RST_FIRST;
			st_r.len_p <= RST_LEN;
			st_r.first_a <= RST_FIRST;
			st_r.len_a <= RST_LEN;
			st_r.hold <= RST_HOLD;
			st_r.t1 <= RST_T1;
			st_r.t3 <= RST_T3;
			st_r.cur <= ADDR_MIN;
			st_r.pst <= P_IDLE;
			st_r.ast <= A_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign probe_node_valid = st_r.pn_v;
	assign probe_node_addr = st_r.pn_a;
	assign admit_valid = st_r.ad_v;
	assign admit_addr = st_r.ad_a;
	assign tag_lookup_valid = st_r.lk_v;
	assign tag_lookup_addr = st_r.lk_a;
	assign set_address_valid = st_r.sa_v;
	assign set_address_addr = st_r.sa_a;
	assign identify_valid = st_r.id_v;
	assign identify_addr = st_r.id_a;
endmodule
`default_nettype wire

// ### src/link_probe_pkg.sv
// Overview of operation
// - master probes every address in its list
// - after last address wrap to first, forever
// - probe gap scales with hold time, devices
// - skip region from first address, given length
// - unprobed address is never admitted
// - eligible addresses run 16 through 255
// - timers count ticks of 1/32 ms
// - tag lookup, identify reply, then set address
// - wait response time, late reply fails assignment
// - identify new address only after probe response
// - moved device rejoins only when probed there
`default_nettype none
package link_probe_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SKIP = 8'h04;
	localparam logic [7:0] OFS_HOLD = 8'h08;
	localparam logic [7:0] OFS_T1 = 8'h0c;
	localparam logic [7:0] OFS_T3 = 8'h10;
	localparam logic [7:0] OFS_ASSIGN = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int ASSIGN_GO_BIT = 31;
	// values after reset
	localparam logic [7:0] RST_FIRST = 8'h00;
	localparam logic [7:0] RST_LEN = 8'h00;
	localparam logic [15:0] RST_HOLD = 16'h0020;
	localparam logic [15:0] RST_T1 = 16'h0140;
	localparam logic [15:0] RST_T3 = 16'h7d00;
	// probe-eligible address range
	localparam logic [7:0] ADDR_MIN = 8'h10;
	localparam logic [7:0] ADDR_MAX = 8'hff;
	// timer tick of 1/32 ms
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 31250;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 12;
	localparam int TMR_W = 24;
	typedef enum logic [1:0] {P_IDLE, P_RESP, P_GAP} probe_st_t;
	typedef enum logic [2:0] {A_IDLE, A_LOOK, A_ID, A_PR, A_IDENT} assign_st_t;
endpackage
`default_nettype wire

// ### src/tick_gen.sv
`default_nettype none
module tick_gen
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// one-cycle pulse every 1/32 ms
	output logic tick
);
	import link_probe_pkg::*;
	typedef struct packed
	{
		logic [TICK_W-1:0] cnt;
		logic tick;
	} tick_st_t;
	tick_st_t st_r;
	tick_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == TICK_W'(TICK_CYCLES - 1))
		begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end
		else
			st_nxt.cnt = st_r.cnt + TICK_W'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick = st_r.tick;
endmodule
`default_nettype wire

// ### src/wait_timer.sv
`default_nettype none
module wait_timer
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// tick and control
	input wire logic tick,
	input wire logic start,
	input wire logic [link_probe_pkg::TMR_W-1:0] limit,
	// level, high from expiry until next start
	output logic expired
);
	import link_probe_pkg::*;
	typedef struct packed
	{
		logic [TMR_W-1:0] cnt;
		logic armed;
		logic expired;
	} tmr_st_t;
	tmr_st_t st_r;
	tmr_st_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (start)
		begin
			st_nxt.cnt = limit;
			st_nxt.armed = 1'b1;
			st_nxt.expired = 1'b0;
		end
		else if (st_r.armed && st_r.cnt == '0)
		begin
			st_nxt.armed = 1'b0;
			st_nxt.expired = 1'b1;
		end
		else if (st_r.armed && tick)
			st_nxt.cnt = st_r.cnt - TMR_W'(1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign expired = st_r.expired;
endmodule
`default_nettype wire

// ### dv/field_device_model.sv
`default_nettype none
module field_device_model
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// packets from the master
	input wire logic probe_node_valid,
	input wire logic [7:0] probe_node_addr,
	input wire logic tag_lookup_valid,
	input wire logic [7:0] tag_lookup_addr,
	input wire logic set_address_valid,
	input wire logic [7:0] set_address_addr,
	// replies
	output logic probe_response_valid,
	output logic [7:0] probe_response_addr,
	output logic identify_resp_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] addr_r;
	logic hit;
	assign hit = probe_node_valid && probe_node_addr == addr_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_r <= 8'h15;
			probe_response_valid <= 1'b0;
			probe_response_addr <= 8'h00;
			identify_resp_valid <= 1'b0;
		end
		else
		begin
			probe_response_valid <= hit;
			// released lines invert, never keep a stale address
			probe_response_addr <= hit ? addr_r : ~probe_response_addr;
			identify_resp_valid <= tag_lookup_valid && tag_lookup_addr == addr_r;
			if (set_address_valid)
				addr_r <= set_address_addr;
		end
	end
endmodule
`default_nettype wire

// ### dv/link_probe_scheduler_asserts.sv
`default_nettype none
module link_probe_checker
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// probe and assignment
	input wire logic probe_node_valid,
	input wire logic [7:0] probe_node_addr,
	input wire logic probe_response_valid,
	input wire logic [7:0] probe_response_addr,
	input wire logic admit_valid,
	input wire logic [7:0] admit_addr,
	input wire logic identify_resp_valid,
	input wire logic set_address_valid,
	input wire logic [7:0] set_address_addr,
	input wire logic identify_valid,
	input wire logic [7:0] identify_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_admit_cause: assert property (
		admit_valid |-> $past(probe_response_valid) && $past(probe_response_addr) == admit_addr
			&& admit_addr == probe_node_addr)
		else $error("admit without response");
	a_probe_range: assert property (
		probe_node_valid |-> probe_node_addr >= 8'h10) else $error("probe below range");
	a_set_after_id: assert property (
		set_address_valid |-> $past(identify_resp_valid)) else $error("set address early");
	a_ident_after_admit: assert property (
		identify_valid |-> $past(admit_valid, 2) && $past(admit_addr, 2) == identify_addr)
		else $error("identify before probe response");
	a_ident_new_addr: assert property (
		identify_valid |-> identify_addr == set_address_addr) else $error("identify wrong address");
	a_probe_gap: assert property (
		probe_node_valid |=> !probe_node_valid [*2]) else $error("probes too close");
	a_probe_hold: assert property (
		!probe_node_valid |-> $stable(probe_node_addr)) else $error("probe address moved");
	a_one_wait: assert property (
		psel && $rose(penable) |-> !pready ##1 pready) else $error("apb wait state wrong");
	a_err_ready: assert property (
		pslverr |-> pready) else $error("error without ready");
endmodule
bind link_probe_scheduler link_probe_checker u_link_probe_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.probe_node_valid(probe_node_valid), .probe_node_addr(probe_node_addr),
	.probe_response_valid(probe_response_valid), .probe_response_addr(probe_response_addr),
	.admit_valid(admit_valid), .admit_addr(admit_addr), .identify_resp_valid(identify_resp_valid),
	.set_address_valid(set_address_valid), .set_address_addr(set_address_addr),
	.identify_valid(identify_valid), .identify_addr(identify_addr));
`default_nettype wire

// ### dv/link_probe_scheduler_tb_top.sv
`default_nettype none
module link_probe_scheduler_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import link_probe_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic probe_node_valid, probe_response_valid, admit_valid, tag_lookup_valid;
	logic identify_resp_valid, set_address_valid, identify_valid;
	logic [7:0] paddr, probe_node_addr, probe_response_addr, admit_addr;
	logic [7:0] tag_lookup_addr, set_address_addr, identify_addr;
	logic [31:0] pwdata, prdata, d;
	int failures, num_checks, n, idx, n_set;
	logic [7:0] pq[$];
	time tq[$];
	logic [31:0] evq[$];
	link_probe_scheduler u_link_probe_scheduler (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .probe_node_valid(probe_node_valid),
		.probe_node_addr(probe_node_addr), .probe_response_valid(probe_response_valid),
		.probe_response_addr(probe_response_addr), .admit_valid(admit_valid), .admit_addr(admit_addr),
		.tag_lookup_valid(tag_lookup_valid), .tag_lookup_addr(tag_lookup_addr),
		.identify_resp_valid(identify_resp_valid), .set_address_valid(set_address_valid),
		.set_address_addr(set_address_addr), .identify_valid(identify_valid), .identify_addr(identify_addr));
	field_device_model u_field_device_model (.pclk(pclk), .presetn(presetn),
		.probe_node_valid(probe_node_valid), .probe_node_addr(probe_node_addr),
		.tag_lookup_valid(tag_lookup_valid), .tag_lookup_addr(tag_lookup_addr),
		.set_address_valid(set_address_valid), .set_address_addr(set_address_addr),
		.probe_response_valid(probe_response_valid), .probe_response_addr(probe_response_addr),
		.identify_resp_valid(identify_resp_valid));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		if (probe_node_valid === 1'b1)
		begin
			pq.push_back(probe_node_addr);
			tq.push_back($time);
		end
		if (tag_lookup_valid === 1'b1)
			evq.push_back({16'h0, 8'h01, tag_lookup_addr});
		if (set_address_valid === 1'b1)
		begin
			n_set++;
			evq.push_back({16'h0, 8'h02, set_address_addr});
		end
		if (admit_valid === 1'b1 && admit_addr === 8'h18)
			evq.push_back({16'h0, 8'h03, admit_addr});
		if (identify_valid === 1'b1)
			evq.push_back({16'h0, 8'h04, identify_addr});
	end
	task tally_and_finish;
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		chk({31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, d, e);
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0, d, e);
	endtask
	task wait_q(input int m);
		for (int k = 0; k < 50000 && pq.size() < m; k++)
			@(posedge pclk);
	endtask
	task seek_first;
		n = pq.size();
		for (int k = 0; k < 20000 && !(pq.size() > n && pq[pq.size()-1] === 8'h10); k++)
			@(posedge pclk);
	endtask
	task t_regs;
		rd(OFS_HOLD);
		chk(d, {16'h0, RST_HOLD});
		rd(OFS_T3);
		chk(d, {16'h0, RST_T3});
		apb(1'b0, 8'h1c, 32'h0, d, e);
		chk({31'h0, e}, 32'h1);
	endtask
	task t_scan;
		wr(OFS_T1, 32'h0);
		wr(OFS_HOLD, 32'h0);
		wr(OFS_SKIP, 32'h0000d020);
		wr(OFS_CTRL, 32'h1);
		seek_first();
		seek_first();
		idx = pq.size() - 1;
		// new region is pending until the wrap
		wr(OFS_SKIP, 32'h0);
		wait_q(idx + 49);
		for (int k = 0; k < 48; k++)
			chk(pq[idx+1+k], k < 15 ? 8'(8'h11 + k) : k < 31 ? 8'(8'he1 + k) : 8'(8'hf1 + k));
		rd(OFS_STATUS);
		chk(d[15:8], 8'h01);
	endtask
	task t_assign;
		wr(OFS_T3, 32'h4);
		evq.delete();
		wr(OFS_ASSIGN, 32'h80001815);
		for (int k = 0; k < 20000 && evq.size() < 4; k++)
			@(posedge pclk);
		chk(evq.size(), 4);
		chk(evq[0], 32'h0115);
		chk(evq[1], 32'h0218);
		chk(evq[2], 32'h0318);
		chk(evq[3], 32'h0418);
		rd(OFS_STATUS);
		chk(d[18:16], 3'b010);
	endtask
	task t_fail;
		wr(OFS_T1, 32'h2);
		n = n_set;
		wr(OFS_ASSIGN, 32'h80004140);
		repeat (3000) @(posedge pclk);
		rd(OFS_STATUS);
		chk(d[18:16], 3'b001);
		repeat (3400) @(posedge pclk);
		rd(OFS_STATUS);
		chk(d[18:16], 3'b100);
		chk(n_set, n);
	endtask
	task t_gap;
		wr(OFS_T1, 32'h0);
		wr(OFS_HOLD, 32'h2);
		n = pq.size();
		wait_q(n + 3);
		// tick phase is free running, so the gap may be short by up to one tick
		chk(tq[n+2] - tq[n+1] >= 93750 && tq[n+2] - tq[n+1] <= 125300, 1);
	endtask
	initial
	begin
		repeat (90000) @(posedge pclk);
		failures++;
		$display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
		tally_and_finish();
	end
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_scan();
		t_assign();
		t_fail();
		t_gap();
		tally_and_finish();
	end
endmodule
`default_nettype wire
